// file: pkg/ead_consts.svh
// Encodings and field sizes shared by the egress action decoder files
`ifndef EAD_CONSTS_SVH
`define EAD_CONSTS_SVH

`define EAD_PROT_NORMAL    2'h0
`define EAD_PROT_IF_ACTIVE 2'h1
`define EAD_PROT_IF_IDLE   2'h2

`define EAD_LABEL_OFF      10'h000

`define EAD_POP_USE_HDR    5'h00
`define EAD_POP_NONE       5'h01
`define EAD_POP_MAX        5'h15

`define EAD_OFS_W          3

`define EAD_KEY_QOS        4'h0
`define EAD_KEY_DP_QOS     4'h1
`define EAD_KEY_DSCP       4'h2
`define EAD_KEY_DP_DSCP    4'h3
`define EAD_KEY_DP_TOS     4'h4
`define EAD_KEY_PCP        4'h5
`define EAD_KEY_DP_PCP     4'h6
`define EAD_KEY_DEI_PCP    4'h7
`define EAD_KEY_TC         4'h8
`define EAD_KEY_DP_TC      4'h9
`define EAD_KEY_PPCP       4'hA
`define EAD_KEY_DP_PPCP    4'hB
`define EAD_KEY_PDEI_PPCP  4'hC
`define EAD_KEY_COS        4'hD
`define EAD_KEY_DP_COS     4'hE

`define EAD_FWD_NONE       2'h0
`define EAD_FWD_COPY       2'h1
`define EAD_FWD_REDIR      2'h2
`define EAD_FWD_DISCARD    2'h3

`define EAD_PACT_EXTRACT   1'h0

`endif

// file: pkg/ead_pkg.sv
// Types shared by the egress action decoder files
package ead_pkg;
  typedef logic [3:0]  ead_key_t;
  typedef logic [8:0]  ead_map_base_t;
  typedef logic [11:0] ead_map_addr_t;
  typedef logic [7:0]  ead_map_ofs_t;
endpackage : ead_pkg

// file: core/ead_map_key.sv
// One mapping-table address builder: base index plus key-selected offset
`timescale 1ns/100ps
`default_nettype none
`include "ead_consts.svh"

module ead_map_key (
  input  wire ead_pkg::ead_map_base_t base_index,
  input  wire ead_pkg::ead_key_t      key,
  input  wire logic [2:0]             qos_class,
  input  wire logic [1:0]             drop_prec,
  input  wire logic [5:0]             dscp,
  input  wire logic [2:0]             tos_precedence,
  input  wire logic [2:0]             pcp,
  input  wire logic                   dei,
  input  wire logic [2:0]             traffic_class,
  input  wire logic [2:0]             popped_pcp,
  input  wire logic                   popped_dei,
  input  wire logic [2:0]             service_class_id,
  output ead_pkg::ead_map_addr_t      map_addr,
  output logic                        map_hit
);

  ead_pkg::ead_map_ofs_t ofs;

  always_comb begin
    ofs     = 8'h00;
    map_hit = 1'b1;
    case (key)
      `EAD_KEY_QOS:       ofs = {5'h00, qos_class};
      `EAD_KEY_DP_QOS:    ofs = {3'h0, drop_prec, qos_class};
      `EAD_KEY_DSCP:      ofs = {2'h0, dscp};
      `EAD_KEY_DP_DSCP:   ofs = {drop_prec, dscp};
      `EAD_KEY_DP_TOS:    ofs = {3'h0, drop_prec, tos_precedence};
      `EAD_KEY_PCP:       ofs = {5'h00, pcp};
      `EAD_KEY_DP_PCP:    ofs = {3'h0, drop_prec, pcp};
      `EAD_KEY_DEI_PCP:   ofs = {4'h0, dei, pcp};
      `EAD_KEY_TC:        ofs = {5'h00, traffic_class};
      `EAD_KEY_DP_TC:     ofs = {3'h0, drop_prec, traffic_class};
      `EAD_KEY_PPCP:      ofs = {5'h00, popped_pcp};
      `EAD_KEY_DP_PPCP:   ofs = {3'h0, drop_prec, popped_pcp};
      `EAD_KEY_PDEI_PPCP: ofs = {4'h0, popped_dei, popped_pcp};
      `EAD_KEY_COS:       ofs = {5'h00, service_class_id};
      `EAD_KEY_DP_COS:    ofs = {3'h0, drop_prec, service_class_id};
      default:            map_hit = 1'b0;
    endcase
  end

  // Base supplies address bits 11:3; the key offset is added on top
  assign map_addr = {base_index, 3'h0} + {4'h0, ofs};

endmodule : ead_map_key
`default_nettype wire

// file: core/ead_decoder.sv
// Egress action decoder: turns a lookup action word into rewriter controls
// How it works
// - Protection selector picks normal or protected indices from header protection flag.
// - Label-stack index zero disables push; nonzero selects the table entry.
// - Protected label-stack index, same encoding, used only when protection chosen.
// - Pop override: 0 keeps header count, 1 pops nothing, n from 2 to 21 pops n words.
// - Override never pops more than the header count; header count wins then.
// - Service base index selects the egress counter set.
// - Protected service base replaces normal base when protection chosen.
// - Counter index is base plus 3-bit offset chosen by class id.
// - Lookups A0 and A1 use index bits 11:3 plus own key offset.
// - Lookups B0 and B1 use index bits 11:3 plus key offset.
// - Each lookup has its own 4-bit key with one shared encoding.
// - Keys 0 and 1 add QoS class, optionally with drop precedence.
// - Keys 2 to 4 add DSCP or type-of-service precedence forms.
// - Keys 5 to 7 add priority code point forms with precedence or DEI.
// - Keys 8 and 9 add traffic class, optionally with drop precedence.
// - Keys 10 to 12 add popped customer tag code point forms.
// - Keys 13 and 14 add stacking class id, optionally with precedence.
// - Forward selector: none, copy to loopback, redirect to loopback, discard.
// - Extraction queue applies only for nonzero forward with extraction action.
// - Pipeline action applies for nonzero forward: extraction or analyzer loop.
`timescale 1ns/100ps
`default_nettype none
`include "ead_consts.svh"

module ead_decoder #(
  parameter int MEP_W = 12,
  parameter int POP_W = 6
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Action word, sampled when act_valid is high
  input  wire logic                act_valid,
  input  wire logic [1:0]          protection_sel,
  input  wire logic [9:0]          label_stack_index,
  input  wire logic [9:0]          label_stack_index_protected,
  input  wire logic [MEP_W-1:0]    maintenance_endpoint_index,
  input  wire logic [MEP_W-1:0]    maintenance_endpoint_index_protected,
  input  wire logic [4:0]          label_pop_override,
  input  wire logic [12:0]         egress_stat_base,
  input  wire logic [12:0]         egress_stat_base_protected,
  input  wire logic [23:0]         per_class_stat_offset,
  input  wire logic [8:0]          lookup_a0_index,
  input  wire logic [8:0]          lookup_a1_index,
  input  wire logic [8:0]          lookup_b0_index,
  input  wire logic [8:0]          lookup_b1_index,
  input  wire logic [3:0]          lookup_a0_key,
  input  wire logic [3:0]          lookup_a1_key,
  input  wire logic [3:0]          lookup_b0_key,
  input  wire logic [3:0]          lookup_b1_key,
  input  wire logic [1:0]          forward_selector,
  input  wire logic [2:0]          extraction_queue,
  input  wire logic                pipeline_action,
  // Frame header fields, valid together with the action word
  input  wire logic                hdr_prot_active,
  input  wire logic [POP_W-1:0]    header_word_pop_count,
  input  wire logic [2:0]          service_class_id,
  input  wire logic [2:0]          hdr_qos_class,
  input  wire logic [1:0]          hdr_drop_prec,
  input  wire logic [5:0]          hdr_dscp,
  input  wire logic [2:0]          tos_precedence,
  input  wire logic [2:0]          hdr_pcp,
  input  wire logic                hdr_dei,
  input  wire logic [2:0]          hdr_traffic_class,
  input  wire logic [2:0]          popped_pcp,
  input  wire logic                popped_dei,
  // Decoded controls, one cycle after act_valid
  output logic                     dec_valid_r,
  output logic                     protect_used_r,
  output logic                     label_push_en_r,
  output logic [9:0]               label_push_index_r,
  output logic [MEP_W-1:0]         mep_index_r,
  output logic [POP_W-1:0]         pop_words_r,
  output logic [12:0]              stat_index_r,
  output logic [11:0]              lookup_a0_addr_r,
  output logic [11:0]              lookup_a1_addr_r,
  output logic [11:0]              lookup_b0_addr_r,
  output logic [11:0]              lookup_b1_addr_r,
  output logic [3:0]               lookup_hit_r,
  output logic                     fwd_copy_r,
  output logic                     fwd_redirect_r,
  output logic                     fwd_discard_r,
  output logic                     extract_en_r,
  output logic                     loop_to_analyzer_r,
  output logic [2:0]               extract_queue_r
);

  // Combinational results of the key builders
  ead_pkg::ead_map_addr_t map_addr_w [4];
  logic [3:0]             map_hit_w;

  // Next values
  logic                   dec_valid_nxt;
  logic                   protect_used_nxt;
  logic                   label_push_en_nxt;
  logic [9:0]             label_push_index_nxt;
  logic [MEP_W-1:0]       mep_index_nxt;
  logic [POP_W-1:0]       pop_words_nxt;
  logic [12:0]            stat_index_nxt;
  logic [11:0]            lookup_a0_addr_nxt;
  logic [11:0]            lookup_a1_addr_nxt;
  logic [11:0]            lookup_b0_addr_nxt;
  logic [11:0]            lookup_b1_addr_nxt;
  logic [3:0]             lookup_hit_nxt;
  logic                   fwd_copy_nxt;
  logic                   fwd_redirect_nxt;
  logic                   fwd_discard_nxt;
  logic                   extract_en_nxt;
  logic                   loop_to_analyzer_nxt;
  logic [2:0]             extract_queue_nxt;

  // Working values of the decode
  logic                   use_prot;
  logic [9:0]             push_idx;
  logic [12:0]            stat_base;
  logic [`EAD_OFS_W-1:0]  class_ofs;
  logic [POP_W-1:0]       ovr_words;
  logic                   fwd_active;

  ead_map_key u_map_a0 (
    .base_index       (lookup_a0_index),
    .key              (lookup_a0_key),
    .qos_class        (hdr_qos_class),
    .drop_prec        (hdr_drop_prec),
    .dscp             (hdr_dscp),
    .tos_precedence   (tos_precedence),
    .pcp              (hdr_pcp),
    .dei              (hdr_dei),
    .traffic_class    (hdr_traffic_class),
    .popped_pcp       (popped_pcp),
    .popped_dei       (popped_dei),
    .service_class_id (service_class_id),
    .map_addr         (map_addr_w[0]),
    .map_hit          (map_hit_w[0])
  );

  ead_map_key u_map_a1 (
    .base_index       (lookup_a1_index),
    .key              (lookup_a1_key),
    .qos_class        (hdr_qos_class),
    .drop_prec        (hdr_drop_prec),
    .dscp             (hdr_dscp),
    .tos_precedence   (tos_precedence),
    .pcp              (hdr_pcp),
    .dei              (hdr_dei),
    .traffic_class    (hdr_traffic_class),
    .popped_pcp       (popped_pcp),
    .popped_dei       (popped_dei),
    .service_class_id (service_class_id),
    .map_addr         (map_addr_w[1]),
    .map_hit          (map_hit_w[1])
  );

  // Each B lookup is keyed by its own key field
  ead_map_key u_map_b0 (
    .base_index       (lookup_b0_index),
    .key              (lookup_b0_key),
    .qos_class        (hdr_qos_class),
    .drop_prec        (hdr_drop_prec),
    .dscp             (hdr_dscp),
    .tos_precedence   (tos_precedence),
    .pcp              (hdr_pcp),
    .dei              (hdr_dei),
    .traffic_class    (hdr_traffic_class),
    .popped_pcp       (popped_pcp),
    .popped_dei       (popped_dei),
    .service_class_id (service_class_id),
    .map_addr         (map_addr_w[2]),
    .map_hit          (map_hit_w[2])
  );

  ead_map_key u_map_b1 (
    .base_index       (lookup_b1_index),
    .key              (lookup_b1_key),
    .qos_class        (hdr_qos_class),
    .drop_prec        (hdr_drop_prec),
    .dscp             (hdr_dscp),
    .tos_precedence   (tos_precedence),
    .pcp              (hdr_pcp),
    .dei              (hdr_dei),
    .traffic_class    (hdr_traffic_class),
    .popped_pcp       (popped_pcp),
    .popped_dei       (popped_dei),
    .service_class_id (service_class_id),
    .map_addr         (map_addr_w[3]),
    .map_hit          (map_hit_w[3])
  );

  always_comb begin
    // Protection decision; reserved selector falls back to normal indices
    case (protection_sel)
      `EAD_PROT_IF_ACTIVE: use_prot = hdr_prot_active;
      `EAD_PROT_IF_IDLE:   use_prot = !hdr_prot_active;
      `EAD_PROT_NORMAL:    use_prot = 1'b0;
      default:             use_prot = 1'b0;
    endcase

    push_idx  = use_prot ? label_stack_index_protected : label_stack_index;
    stat_base = use_prot ? egress_stat_base_protected : egress_stat_base;
    class_ofs = per_class_stat_offset[service_class_id*`EAD_OFS_W +: `EAD_OFS_W];

    // Override widened to the header count width before comparing
    ovr_words  = {{(POP_W-5){1'b0}}, label_pop_override};
    fwd_active = (forward_selector != `EAD_FWD_NONE);

    // Hold the last decode between action words
    dec_valid_nxt        = act_valid;
    protect_used_nxt     = protect_used_r;
    label_push_en_nxt    = label_push_en_r;
    label_push_index_nxt = label_push_index_r;
    mep_index_nxt        = mep_index_r;
    pop_words_nxt        = pop_words_r;
    stat_index_nxt       = stat_index_r;
    lookup_a0_addr_nxt   = lookup_a0_addr_r;
    lookup_a1_addr_nxt   = lookup_a1_addr_r;
    lookup_b0_addr_nxt   = lookup_b0_addr_r;
    lookup_b1_addr_nxt   = lookup_b1_addr_r;
    lookup_hit_nxt       = lookup_hit_r;
    fwd_copy_nxt         = fwd_copy_r;
    fwd_redirect_nxt     = fwd_redirect_r;
    fwd_discard_nxt      = fwd_discard_r;
    extract_en_nxt       = extract_en_r;
    loop_to_analyzer_nxt = loop_to_analyzer_r;
    extract_queue_nxt    = extract_queue_r;

    if (act_valid) begin
      protect_used_nxt     = use_prot;
      label_push_en_nxt    = (push_idx != `EAD_LABEL_OFF);
      label_push_index_nxt = push_idx;
      mep_index_nxt        = use_prot ? maintenance_endpoint_index_protected
                                      : maintenance_endpoint_index;
      stat_index_nxt       = stat_base + {10'h000, class_ofs};

      // Pop count; reserved override codes leave the header count alone
      if (label_pop_override == `EAD_POP_USE_HDR ||
          label_pop_override > `EAD_POP_MAX) begin
        pop_words_nxt = header_word_pop_count;
      end else if (label_pop_override == `EAD_POP_NONE) begin
        pop_words_nxt = '0;
      end else if (ovr_words > header_word_pop_count) begin
        pop_words_nxt = header_word_pop_count;
      end else begin
        pop_words_nxt = ovr_words;
      end

      lookup_a0_addr_nxt = map_addr_w[0];
      lookup_a1_addr_nxt = map_addr_w[1];
      lookup_b0_addr_nxt = map_addr_w[2];
      lookup_b1_addr_nxt = map_addr_w[3];
      lookup_hit_nxt     = map_hit_w;

      fwd_copy_nxt     = (forward_selector == `EAD_FWD_COPY);
      fwd_redirect_nxt = (forward_selector == `EAD_FWD_REDIR);
      fwd_discard_nxt  = (forward_selector == `EAD_FWD_DISCARD);

      // Pipeline action is meaningless without a forward action
      extract_en_nxt       = fwd_active &&
                             (pipeline_action == `EAD_PACT_EXTRACT);
      loop_to_analyzer_nxt = fwd_active &&
                             (pipeline_action != `EAD_PACT_EXTRACT);
      // Queue is zeroed when unused so stale values never leak downstream
      extract_queue_nxt    = (fwd_active &&
                              pipeline_action == `EAD_PACT_EXTRACT)
                             ? extraction_queue : 3'h0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_valid_r        <= 1'b0;
      protect_used_r     <= 1'b0;
      label_push_en_r    <= 1'b0;
      label_push_index_r <= 10'h000;
      mep_index_r        <= '0;
      pop_words_r        <= '0;
      stat_index_r       <= 13'h0000;
      lookup_a0_addr_r   <= 12'h000;
      lookup_a1_addr_r   <= 12'h000;
      lookup_b0_addr_r   <= 12'h000;
      lookup_b1_addr_r   <= 12'h000;
      lookup_hit_r       <= 4'h0;
      fwd_copy_r         <= 1'b0;
      fwd_redirect_r     <= 1'b0;
      fwd_discard_r      <= 1'b0;
      extract_en_r       <= 1'b0;
      loop_to_analyzer_r <= 1'b0;
      extract_queue_r    <= 3'h0;
    end else begin
      dec_valid_r        <= dec_valid_nxt;
      protect_used_r     <= protect_used_nxt;
      label_push_en_r    <= label_push_en_nxt;
      label_push_index_r <= label_push_index_nxt;
      mep_index_r        <= mep_index_nxt;
      pop_words_r        <= pop_words_nxt;
      stat_index_r       <= stat_index_nxt;
      lookup_a0_addr_r   <= lookup_a0_addr_nxt;
      lookup_a1_addr_r   <= lookup_a1_addr_nxt;
      lookup_b0_addr_r   <= lookup_b0_addr_nxt;
      lookup_b1_addr_r   <= lookup_b1_addr_nxt;
      lookup_hit_r       <= lookup_hit_nxt;
      fwd_copy_r         <= fwd_copy_nxt;
      fwd_redirect_r     <= fwd_redirect_nxt;
      fwd_discard_r      <= fwd_discard_nxt;
      extract_en_r       <= extract_en_nxt;
      loop_to_analyzer_r <= loop_to_analyzer_nxt;
      extract_queue_r    <= extract_queue_nxt;
    end
  end

endmodule : ead_decoder
`default_nettype wire

// file: sim/ead_decoder_properties.sv
// Checker for the egress action decoder ports
`timescale 1ns/100ps
`default_nettype none
module ead_decoder_properties #(
  parameter int POP_W = 6
) (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             act_valid,
  input wire logic [1:0]       protection_sel,
  input wire logic             hdr_prot_active,
  input wire logic [9:0]       label_stack_index,
  input wire logic [9:0]       label_stack_index_protected,
  input wire logic [4:0]       label_pop_override,
  input wire logic [POP_W-1:0] header_word_pop_count,
  input wire logic [12:0]      egress_stat_base,
  input wire logic [12:0]      egress_stat_base_protected,
  input wire logic [23:0]      per_class_stat_offset,
  input wire logic [2:0]       service_class_id,
  input wire logic [1:0]       forward_selector,
  input wire logic [2:0]       extraction_queue,
  input wire logic             pipeline_action,
  input wire logic             dec_valid_r,
  input wire logic             protect_used_r,
  input wire logic             label_push_en_r,
  input wire logic [9:0]       label_push_index_r,
  input wire logic [POP_W-1:0] pop_words_r,
  input wire logic [12:0]      stat_index_r,
  input wire logic             fwd_copy_r,
  input wire logic             fwd_redirect_r,
  input wire logic             fwd_discard_r,
  input wire logic             extract_en_r,
  input wire logic             loop_to_analyzer_r,
  input wire logic [2:0]       extract_queue_r
);
  wire logic prot = (protection_sel == 2'h1 && hdr_prot_active)
                 || (protection_sel == 2'h2 && !hdr_prot_active);
  wire logic [12:0] sbase = prot ? egress_stat_base_protected : egress_stat_base;
  wire logic [2:0] ofs = per_class_stat_offset[3*service_class_id +: 3];
  wire logic fwd_on = forward_selector != 2'h0;
  logic [POP_W-1:0] exp_pop;
  // Reserved override codes fall back to the header count
  always_comb begin
    if (label_pop_override == 5'h01) exp_pop = '0;
    else if (label_pop_override == 5'h00 || label_pop_override > 5'h15
             || label_pop_override > header_word_pop_count) exp_pop = header_word_pop_count;
    else exp_pop = POP_W'(label_pop_override);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_PULSE: assert property (act_valid |=> dec_valid_r)
    else $error("decode pulse missing");
  AST_HOLD: assert property (!act_valid |=> !dec_valid_r && $stable(stat_index_r)
    && $stable(pop_words_r)) else $error("outputs moved while idle");
  AST_PROT: assert property (act_valid |=> protect_used_r == $past(prot))
    else $error("protection choice wrong");
  AST_LABEL: assert property (act_valid |=> label_push_en_r == (label_push_index_r != 10'h000)
    && label_push_index_r == ($past(prot) ? $past(label_stack_index_protected)
    : $past(label_stack_index))) else $error("label index wrong");
  AST_STAT: assert property (act_valid |=> stat_index_r == $past(sbase) + $past(ofs))
    else $error("stat index wrong");
  AST_POP: assert property (act_valid |=> pop_words_r == $past(exp_pop))
    else $error("pop count wrong");
  AST_FWD: assert property (act_valid |=> {fwd_copy_r, fwd_redirect_r, fwd_discard_r} ==
    {$past(forward_selector) == 2'h1, $past(forward_selector) == 2'h2,
    $past(forward_selector) == 2'h3}) else $error("forward flags wrong");
  AST_ACT: assert property (act_valid |=> extract_en_r == $past(fwd_on && !pipeline_action)
    && loop_to_analyzer_r == $past(fwd_on && pipeline_action)) else $error("action wrong");
  AST_QUEUE: assert property (act_valid |=> extract_queue_r ==
    ($past(fwd_on && !pipeline_action) ? $past(extraction_queue) : 3'h0))
    else $error("queue wrong");
  cover property (act_valid && prot);
  cover property (act_valid && label_pop_override > header_word_pop_count);
  cover property (act_valid && forward_selector == 2'h3);
endmodule : ead_decoder_properties
bind ead_decoder ead_decoder_properties #(.POP_W(POP_W)) i_props (.*);
`default_nettype wire

// file: sim/ead_rewriter_model.sv
// Behavioural rewriter sink that counts decode results it accepts
`timescale 1ns/100ps
`default_nettype none
module ead_rewriter_model (
  input  wire logic    clk,
  input  wire logic    sys_rst,
  input  wire logic    dec_valid_r,
  output logic  [15:0] decode_count_r
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) decode_count_r <= 16'h0000;
    else if (dec_valid_r) decode_count_r <= decode_count_r + 16'h0001;
  end
endmodule : ead_rewriter_model
`default_nettype wire

// file: sim/ead_decoder_test.sv
// Self-checking testbench for the egress action decoder
`timescale 1ns/100ps
`default_nettype none
module ead_decoder_test;
  logic clk = 1'b0, sys_rst = 1'b1, act_valid = 1'b0, hdr_prot_active = 1'b0;
  logic pipeline_action = 1'b0, hdr_dei = 1'b1, popped_dei = 1'b1;
  logic [1:0] protection_sel = '0, forward_selector = '0, hdr_drop_prec = 2'h3;
  logic [2:0] extraction_queue = 3'h5, service_class_id = 3'h3, hdr_qos_class = 3'h5;
  logic [2:0] tos_precedence = 3'h6, hdr_pcp = 3'h2, hdr_traffic_class = 3'h7;
  logic [2:0] popped_pcp = 3'h4;
  logic [3:0] lookup_a0_key = '0, lookup_a1_key = '0, lookup_b0_key = '0, lookup_b1_key = '0;
  logic [4:0] label_pop_override = '0;
  logic [5:0] hdr_dscp = 6'h2D, header_word_pop_count = '0;
  logic [8:0] lookup_a0_index = 9'h1FF, lookup_a1_index = 9'h001;
  logic [8:0] lookup_b0_index = 9'h0AA, lookup_b1_index = 9'h155;
  logic [9:0] label_stack_index = 10'h155, label_stack_index_protected = 10'h2AA;
  logic [11:0] maintenance_endpoint_index = 12'hA51;
  logic [11:0] maintenance_endpoint_index_protected = 12'h0BC;
  logic [12:0] egress_stat_base = 13'h1FFD, egress_stat_base_protected = 13'h0010;
  logic [23:0] per_class_stat_offset = 24'h053977;
  logic dec_valid_r, protect_used_r, label_push_en_r, fwd_copy_r, fwd_redirect_r;
  logic fwd_discard_r, extract_en_r, loop_to_analyzer_r;
  logic [2:0] extract_queue_r;
  logic [3:0] lookup_hit_r;
  logic [5:0] pop_words_r;
  logic [9:0] label_push_index_r;
  logic [11:0] mep_index_r, lookup_a0_addr_r, lookup_a1_addr_r, lookup_b0_addr_r, lookup_b1_addr_r;
  logic [12:0] stat_index_r;
  logic [15:0] decode_count_r;
  int num_errors = 0, cmp_count = 0, sent = 0;
  ead_decoder i_dut (.*);
  ead_rewriter_model i_sink (.clk, .sys_rst, .dec_valid_r, .decode_count_r);
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // Back-to-back sends keep act_valid high, so no signal is driven twice per step
  task automatic send;
    act_valid = 1'b1;
    sent++;
    @(negedge clk);
    chk(dec_valid_r, 1'b1);
  endtask : send
  task automatic idle;
    act_valid = 1'b0;
    @(negedge clk);
    chk(dec_valid_r, 1'b0);
  endtask : idle
  task automatic t_prot;
    logic p;
    per_class_stat_offset = '0;
    for (int s = 0; s < 8; s++) begin
      protection_sel = s[2:1];
      hdr_prot_active = s[0];
      send;
      p = (s[2:1] == 2'h1 && s[0]) || (s[2:1] == 2'h2 && !s[0]);
      chk(protect_used_r, p);
      chk(label_push_index_r, p ? 10'h2AA : 10'h155);
      chk(mep_index_r, p ? 12'h0BC : 12'hA51);
      chk(stat_index_r, p ? 13'h0010 : 13'h1FFD);
    end
    idle;
    $display("t_prot done");
  endtask : t_prot
  task automatic t_label;
    for (int i = 0; i < 4; i++) begin
      protection_sel = (i == 3) ? 2'h1 : 2'h0;
      hdr_prot_active = 1'b1;
      label_stack_index = (i == 1) ? 10'h001 : (i == 2) ? 10'h3FF : 10'h000;
      label_stack_index_protected = 10'h000;
      send;
      chk(label_push_en_r, i == 1 || i == 2);
    end
    idle;
    $display("t_label done");
  endtask : t_label
  task automatic t_pop;
    logic [4:0] ov [8] = '{5'h00, 5'h01, 5'h02, 5'h15, 5'h15, 5'h15, 5'h16, 5'h1F};
    logic [5:0] hd [8] = '{6'h07, 6'h07, 6'h07, 6'h1E, 6'h15, 6'h05, 6'h09, 6'h03};
    logic [5:0] ex [8] = '{6'h07, 6'h00, 6'h02, 6'h15, 6'h15, 6'h05, 6'h09, 6'h03};
    for (int i = 0; i < 8; i++) begin
      label_pop_override = ov[i];
      header_word_pop_count = hd[i];
      send;
      chk(pop_words_r, ex[i]);
    end
    idle;
    $display("t_pop done");
  endtask : t_pop
  task automatic t_stat;
    per_class_stat_offset = 24'h053977;
    hdr_prot_active = 1'b0;
    for (int j = 0; j < 2; j++) begin
      for (int c = 0; c < 8; c++) begin
        protection_sel = (j == 1) ? 2'h2 : 2'h0;
        service_class_id = c[2:0];
        send;
        chk(stat_index_r, 13'(((j == 1) ? 13'h0010 : 13'h1FFD) + 13'(7 - c)));
      end
    end
    service_class_id = 3'h3;
    idle;
    $display("t_stat done");
  endtask : t_stat
  function automatic logic [7:0] kofs(input logic [3:0] k);
    case (k)
      4'h0: kofs = {5'h00, hdr_qos_class};
      4'h1: kofs = {3'h0, hdr_drop_prec, hdr_qos_class};
      4'h2: kofs = {2'h0, hdr_dscp};
      4'h3: kofs = {hdr_drop_prec, hdr_dscp};
      4'h4: kofs = {3'h0, hdr_drop_prec, tos_precedence};
      4'h5: kofs = {5'h00, hdr_pcp};
      4'h6: kofs = {3'h0, hdr_drop_prec, hdr_pcp};
      4'h7: kofs = {4'h0, hdr_dei, hdr_pcp};
      4'h8: kofs = {5'h00, hdr_traffic_class};
      4'h9: kofs = {3'h0, hdr_drop_prec, hdr_traffic_class};
      4'hA: kofs = {5'h00, popped_pcp};
      4'hB: kofs = {3'h0, hdr_drop_prec, popped_pcp};
      4'hC: kofs = {4'h0, popped_dei, popped_pcp};
      4'hD: kofs = {5'h00, service_class_id};
      4'hE: kofs = {3'h0, hdr_drop_prec, service_class_id};
      default: kofs = 8'h00;
    endcase
  endfunction : kofs
  task automatic t_keys;
    for (int k = 0; k < 16; k++) begin
      lookup_a0_key = k[3:0];
      lookup_a1_key = k[3:0];
      lookup_b0_key = k[3:0];
      lookup_b1_key = 4'(15 - k);
      send;
      chk(lookup_a0_addr_r, 12'({9'h1FF, 3'h0} + kofs(k[3:0])));
      chk(lookup_a1_addr_r, 12'({9'h001, 3'h0} + kofs(k[3:0])));
      chk(lookup_b0_addr_r, 12'({9'h0AA, 3'h0} + kofs(k[3:0])));
      chk(lookup_b1_addr_r, 12'({9'h155, 3'h0} + kofs(4'(15 - k))));
      chk(lookup_hit_r, {k != 0, k != 15, k != 15, k != 15});
    end
    idle;
    $display("t_keys done");
  endtask : t_keys
  task automatic t_fwd;
    for (int i = 0; i < 8; i++) begin
      forward_selector = i[1:0];
      pipeline_action = i[2];
      send;
      chk({fwd_copy_r, fwd_redirect_r, fwd_discard_r},
          {i[1:0] == 2'h1, i[1:0] == 2'h2, i[1:0] == 2'h3});
      chk({extract_en_r, loop_to_analyzer_r},
          {i[1:0] != 2'h0 && !i[2], i[1:0] != 2'h0 && i[2]});
      chk(extract_queue_r, (i[1:0] != 2'h0 && !i[2]) ? 3'h5 : 3'h0);
    end
    forward_selector = 2'h0;
    idle;
    idle;
    chk(fwd_discard_r, 1'b1);
    chk(decode_count_r, sent);
    $display("t_fwd done");
  endtask : t_fwd
  // Mid-run reset must clear held decodes; a word is legal on the first edge after
  task automatic t_rst;
    sys_rst = 1'b1;
    @(negedge clk);
    chk({fwd_discard_r, extract_queue_r, stat_index_r}, 17'h00000);
    sys_rst = 1'b0;
    send;
    chk(pop_words_r, 6'h03);
    idle;
    chk(decode_count_r, 16'h0001);
    $display("t_rst done");
  endtask : t_rst
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_prot;
    t_label;
    t_pop;
    t_stat;
    t_keys;
    t_fwd;
    t_rst;
    end_sim;
  end
  initial begin
    #200000;
    num_errors++;
    end_sim;
  end
endmodule : ead_decoder_test
`default_nettype wire
